/* hdl/gpib_status_reporting.sv */
// status reporting, interface clears and remote/local state of gpib port
`include "gpib_status_map.svh"
`default_nettype none
module gpib_status_reporting (
   input  wire logic                      core_clk,    // 20 MHz clock
   input  wire logic                      rstn,        // power-up reset
   input  wire gpib_status_pkg::events_t  ev,          // event pulses
   input  wire logic                      lbus_err,    // local bus error
   input  wire logic                      lbus_tmo,    // local bus timeout
   input  wire logic                      mav,         // queue not empty
   input  wire logic                      ese_wr,      // enable mask write
   input  wire logic                      sre_wr,      // request mask write
   input  wire logic [7:0]                wr_data,     // write value
   input  wire logic                      ese_rd,      // enable mask query
   input  wire logic                      esr_rd,      // event status query
   input  wire logic                      stb_rd,      // status byte query
   input  wire logic                      cls_cmd,     // clear status
   input  wire logic                      rst_cmd,     // reset command
   input  wire gpib_status_pkg::bus_msg_t msg,         // bus message
   input  wire logic                      msg_vld,     // message strobe
   input  wire logic                      ifc,         // interface clear
   input  wire logic                      my_listen,   // own listen addr
   input  wire logic                      my_talk,     // own talk addr
   input  wire logic                      poll_rd,     // poll byte taken
   input  wire logic                      ren_pin,     // remote enable
   input  wire logic                      local_key,   // panel local key
   output logic [7:0]                     reply_data,  // query value
   output logic                           reply_vld,   // query pulse
   output logic [7:0]                     poll_data,   // serial poll byte
   output logic                           srq,         // service request
   output logic                           talker,      // talker addressed
   output logic                           listener,    // listener addressed
   output logic                           poll_mode,   // serial poll on
   output logic                           buf_clear,   // flush pulse
   output gpib_status_pkg::rl_state_t     rl_state,    // remote/local
   output logic                           lockout,     // lockout set
   output logic                           keys_ok,     // panel keys work
   output logic                           key_local_ok // local key works
);
   logic [7:0] esr_ff, ese_ff, sre_ff, reply_data_ff, status_byte;
   logic       local_bus_error_ff, tmo_ff, rqs_ff, mss_d_ff, reply_vld_ff;
   logic       talker_ff, listener_ff, spe_ff, llo_ff, buf_clear_ff;
   logic [`SYNC_STAGES-1:0] ren_sync_ff, key_sync_ff;
   logic       ren_ff, key_ff, key_d_ff, mss, key_press, poll_ok;
   logic       dcl, sdc, gtl, dev_clear, sb_clear;
   logic [7:0] ev_bits;
   gpib_status_pkg::rl_state_t rl_ff, nxt_rl;

   function automatic logic [7:0] used_esr(input logic [7:0] v);
      used_esr = v & `ESR_USED_MASK;
   endfunction

   // only the listed messages decode; the ignored ones fall through
   assign dcl       = msg_vld && (msg == gpib_status_pkg::MSG_DCL);
   assign sdc       = msg_vld && (msg == gpib_status_pkg::MSG_SDC)
                      && listener_ff;
   assign gtl       = msg_vld && (msg == gpib_status_pkg::MSG_GTL)
                      && listener_ff;
   assign dev_clear = dcl || sdc;
   assign sb_clear  = cls_cmd || dev_clear || rst_cmd;
   assign poll_ok   = poll_rd && spe_ff && talker_ff;

   always_comb begin
      ev_bits = 8'h00;
      ev_bits[`ESR_CME_BIT] = ev.cmd_error;
      ev_bits[`ESR_EXE_BIT] = ev.exec_error;
      ev_bits[`ESR_ALM_BIT] = ev.alarm_flag;
      ev_bits[`ESR_OPC_BIT] = ev.op_complete;
   end

   // new events win over a same-cycle read or clear
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         esr_ff <= `ESR_RESET_VAL;
      end else if (esr_rd || cls_cmd || dev_clear) begin
         esr_ff <= ev_bits;
      end else begin
         esr_ff <= esr_ff | ev_bits;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn || rst_cmd) begin
         ese_ff <= `ESE_RESET_VAL;
         sre_ff <= `SRE_RESET_VAL;
      end else begin
         if (ese_wr) begin
            ese_ff <= used_esr(wr_data);
         end
         if (sre_wr) begin
            sre_ff <= wr_data & `SRE_USED_MASK;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         local_bus_error_ff <= 1'b0;
         tmo_ff  <= 1'b0;
      end else begin
         local_bus_error_ff <= lbus_err || (local_bus_error_ff && !sb_clear);
         tmo_ff  <= lbus_tmo || (tmo_ff && !sb_clear);
      end
   end

   always_comb begin
      status_byte = 8'h00;
      status_byte[`STB_ESB_BIT]  = |(esr_ff & ese_ff);
      status_byte[`STB_MAV_BIT]  = mav;
      status_byte[`STB_LOCAL_BUS_ERROR_BIT] = local_bus_error_ff;
      status_byte[`STB_TMO_BIT]  = tmo_ff;
   end
   assign mss = |(status_byte & sre_ff);

   // set on the rise wins over a poll in the same cycle
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         rqs_ff   <= 1'b0;
         mss_d_ff <= 1'b0;
      end else begin
         mss_d_ff <= mss;
         if (!mss || sb_clear) begin
            rqs_ff <= 1'b0;
         end else if (!mss_d_ff) begin
            rqs_ff <= 1'b1;
         end else if (poll_ok) begin
            rqs_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         reply_data_ff <= 8'h00;
         reply_vld_ff  <= 1'b0;
      end else begin
         reply_vld_ff <= esr_rd || ese_rd || stb_rd;
         if (esr_rd) begin
            reply_data_ff <= esr_ff;
         end else if (ese_rd) begin
            reply_data_ff <= ese_ff;
         end else if (stb_rd) begin
            reply_data_ff <= status_byte | {1'b0, mss, 6'h00};
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         talker_ff    <= 1'b0;
         listener_ff  <= 1'b0;
         spe_ff       <= 1'b0;
         buf_clear_ff <= 1'b0;
      end else begin
         buf_clear_ff <= dev_clear || rst_cmd;
         if (ifc || dev_clear || rst_cmd) begin
            talker_ff   <= 1'b0;
            listener_ff <= 1'b0;
         end else begin
            if (my_talk) begin
               talker_ff <= 1'b1;
            end else if (msg_vld && msg == gpib_status_pkg::MSG_UNT) begin
               talker_ff <= 1'b0;
            end
            if (my_listen) begin
               listener_ff <= 1'b1;
            end else if (msg_vld && msg == gpib_status_pkg::MSG_UNL) begin
               listener_ff <= 1'b0;
            end
         end
         if (ifc || (msg_vld && msg == gpib_status_pkg::MSG_SPD)) begin
            spe_ff <= 1'b0;
         end else if (msg_vld && msg == gpib_status_pkg::MSG_SPE) begin
            spe_ff <= 1'b1;
         end
      end
   end

   // pins: a level counts once stages two and three agree
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         ren_sync_ff <= '0;
         key_sync_ff <= '0;
         ren_ff      <= 1'b0;
         key_ff      <= 1'b0;
         key_d_ff    <= 1'b0;
      end else begin
         ren_sync_ff <= {ren_sync_ff[`SYNC_STAGES-2:0], ren_pin};
         key_sync_ff <= {key_sync_ff[`SYNC_STAGES-2:0], local_key};
         if (ren_sync_ff[1] == ren_sync_ff[2]) begin
            ren_ff <= ren_sync_ff[2];
         end
         if (key_sync_ff[1] == key_sync_ff[2]) begin
            key_ff <= key_sync_ff[2];
         end
         key_d_ff <= key_ff;
      end
   end
   assign key_press = key_ff && !key_d_ff;

   always_comb begin
      nxt_rl = rl_ff;
      case (rl_ff)
         gpib_status_pkg::RL_LOCAL: begin
            if (ren_ff && my_listen) begin
               nxt_rl = llo_ff ? gpib_status_pkg::RL_REMOTE_LLO
                               : gpib_status_pkg::RL_REMOTE;
            end
         end
         gpib_status_pkg::RL_REMOTE: begin
            if (gtl || key_press) begin
               nxt_rl = gpib_status_pkg::RL_LOCAL;
            end else if (msg_vld && msg == gpib_status_pkg::MSG_LLO) begin
               nxt_rl = gpib_status_pkg::RL_REMOTE_LLO;
            end
         end
         gpib_status_pkg::RL_REMOTE_LLO: begin
            if (gtl) begin
               nxt_rl = gpib_status_pkg::RL_LOCAL;
            end
         end
         default: nxt_rl = gpib_status_pkg::RL_LOCAL;
      endcase
      if (!ren_ff || dev_clear) begin
         nxt_rl = gpib_status_pkg::RL_LOCAL;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         rl_ff  <= gpib_status_pkg::RL_LOCAL;
         llo_ff <= 1'b0;
      end else begin
         rl_ff <= nxt_rl;
         if (!ren_ff || dev_clear) begin
            llo_ff <= 1'b0;
         end else if (msg_vld && msg == gpib_status_pkg::MSG_LLO) begin
            llo_ff <= 1'b1;
         end
      end
   end

   assign reply_data   = reply_data_ff;
   assign reply_vld    = reply_vld_ff;
   assign poll_data    = status_byte | {1'b0, rqs_ff, 6'h00};
   assign srq          = rqs_ff;
   assign talker       = talker_ff;
   assign listener     = listener_ff;
   assign poll_mode    = spe_ff;
   assign buf_clear    = buf_clear_ff;
   assign rl_state     = rl_ff;
   assign lockout      = llo_ff;
   assign keys_ok      = (rl_ff == gpib_status_pkg::RL_LOCAL);
   assign key_local_ok = (rl_ff != gpib_status_pkg::RL_REMOTE_LLO);

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   AST_UNUSED_ZERO: assert property (
      (ese_ff & ~`ESR_USED_MASK) == 8'h00
      && (esr_ff & ~`ESR_USED_MASK) == 8'h00) else $error("unused set");
   AST_PON_AFTER_RESET: assert property ($rose(rstn) |->
      esr_ff == `ESR_RESET_VAL && ese_ff == 8'h00) else $error("pon");
   AST_ESR_READ_CLEAR: assert property (
      esr_rd && ev_bits == 8'h00 |=> esr_ff == 8'h00
      && reply_data == $past(esr_ff)) else $error("esr");
   AST_CME_STICKY: assert property (
      ev.cmd_error |=> esr_ff[`ESR_CME_BIT] ##1 (esr_ff[`ESR_CME_BIT]
      || $past(esr_rd || sb_clear))) else $error("cme");
   // write, idle gap, then query: the spacing a controller really uses
   AST_ESE_READBACK: assert property (
      ese_wr && !rst_cmd ##1 !ese_wr && !rst_cmd ##1 ese_rd && !esr_rd
      && !ese_wr && !rst_cmd |=> reply_data
      == ($past(wr_data, 3) & `ESR_USED_MASK)) else $error("ese readback");
   AST_RQS_RISE: assert property ($rose(mss) && !sb_clear |=> srq)
      else $error("rqs rise");
   AST_RQS_FALL: assert property (!mss |=> !srq) else $error("rqs");
   AST_STB_QUERY: assert property (
      stb_rd && !esr_rd && !ese_rd |=> reply_vld
      && reply_data[`STB_MSS_BIT] == $past(mss)) else $error("stb");
   AST_DCL_LOCAL: assert property (dcl |=>
      rl_state == gpib_status_pkg::RL_LOCAL && !lockout && !talker
      && !listener && buf_clear) else $error("dcl");
   AST_IFC_KEEP: assert property (
      ifc && !msg_vld && ren_ff && !my_listen && !key_press
      |=> rl_state == $past(rl_state) && !talker && !listener)
      else $error("ifc");
   COV_SRQ_POLL: cover property ($rose(srq) ##[1:20] poll_ok);
   COV_LOCKOUT: cover property (rl_state == gpib_status_pkg::RL_REMOTE_LLO);
   COV_ESR_READ: cover property (esr_rd && esr_ff != 8'h00);
endmodule
`default_nettype wire

/* hdl/gpib_status_map.svh */
// constants: bit positions, masks, reset values and sync depth
`ifndef GPIB_STATUS_MAP_SVH
`define GPIB_STATUS_MAP_SVH
`define ESR_PON_BIT     7
`define ESR_CME_BIT     5
`define ESR_EXE_BIT     4
`define ESR_ALM_BIT     3
`define ESR_OPC_BIT     0
`define ESR_USED_MASK   8'hB9
`define ESR_RESET_VAL   8'h80
`define ESE_RESET_VAL   8'h00
`define SRE_RESET_VAL   8'h00
`define STB_MSS_BIT     6
`define STB_ESB_BIT     5
`define STB_MAV_BIT     4
`define STB_LOCAL_BUS_ERROR_BIT    1
`define STB_TMO_BIT     0
`define SRE_USED_MASK   8'hBF
`define SYNC_STAGES     3
`endif

/* hdl/gpib_status_pkg.sv */
// types shared by the status-reporting block and its bench
`default_nettype none
package gpib_status_pkg;
   typedef enum logic [3:0] {
      MSG_NONE = 4'h0, MSG_DCL = 4'h1, MSG_SPE = 4'h2, MSG_SPD = 4'h3,
      MSG_PPU  = 4'h4, MSG_LLO = 4'h5, MSG_UNL = 4'h6, MSG_UNT = 4'h7,
      MSG_SDC  = 4'h8, MSG_PPC = 4'h9, MSG_GTL = 4'hA, MSG_GET = 4'hB,
      MSG_TCT  = 4'hC
   } bus_msg_t;
   typedef enum logic [1:0] {
      RL_LOCAL      = 2'b00,
      RL_REMOTE     = 2'b01,
      RL_REMOTE_LLO = 2'b10
   } rl_state_t;
   typedef struct packed {
      logic cmd_error;
      logic exec_error;
      logic alarm_flag;
      logic op_complete;
   } events_t;
endpackage
`default_nettype wire

/* dv/gpib_ctl_model.sv */
// controller-side model: bus messages, addressing, poll and remote enable
`default_nettype none
module gpib_ctl_model (
   input  wire logic                 core_clk,  // bench clock
   output gpib_status_pkg::bus_msg_t msg,       // bus message
   output logic                      msg_vld,   // message strobe
   output logic                      ifc,       // interface clear
   output logic                      my_listen, // listen address
   output logic                      my_talk,   // talk address
   output logic                      poll_rd,   // poll byte taken
   output logic                      ren_pin    // remote enable
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] s;
   assign ifc = s[0];
   assign my_listen = s[1];
   assign my_talk = s[2];
   assign poll_rd = s[3];
   initial begin
      s = 4'h0;
      msg = gpib_status_pkg::MSG_NONE;
      msg_vld = 1'b0;
      ren_pin = 1'b0;
   end
   // message lines are not left holding the last code once released
   task send(input gpib_status_pkg::bus_msg_t m);
      @(negedge core_clk);
      msg = m;
      msg_vld = 1'b1;
      @(negedge core_clk);
      msg_vld = 1'b0;
      msg = gpib_status_pkg::bus_msg_t'(~m);
   endtask
   task hit(input int k);
      @(negedge core_clk);
      s[k] = 1'b1;
      @(negedge core_clk);
      s[k] = 1'b0;
   endtask
   task poll();
      send(gpib_status_pkg::MSG_SPE);
      hit(2);
      hit(3);
   endtask
   task ren(input logic v);
      @(negedge core_clk);
      ren_pin = v;
   endtask
endmodule
`default_nettype wire

/* dv/tb_gpib_status_reporting.sv */
// self-checking bench for the gpib status-reporting block
`include "gpib_status_map.svh"
`default_nettype none
module tb_gpib_status_reporting;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] LC = 8'(gpib_status_pkg::RL_LOCAL);
   localparam logic [7:0] RM = 8'(gpib_status_pkg::RL_REMOTE);
   localparam logic [7:0] LK = 8'(gpib_status_pkg::RL_REMOTE_LLO);
   logic core_clk, rstn, mav, local_key, reply_vld, srq, talker, listener;
   logic poll_mode, buf_clear, lockout, keys_ok, key_local_ok;
   logic msg_vld, ifc, my_listen, my_talk, poll_rd, ren_pin;
   logic [8:0] p;
   logic [7:0] wr_data, reply_data, poll_data, v;
   gpib_status_pkg::events_t  ev;
   gpib_status_pkg::bus_msg_t msg;
   gpib_status_pkg::rl_state_t rl_state;
   gpib_status_pkg::bus_msg_t ign [4] = '{gpib_status_pkg::MSG_PPU,
      gpib_status_pkg::MSG_PPC, gpib_status_pkg::MSG_GET,
      gpib_status_pkg::MSG_TCT};
   logic [7:0] exq[$];
   int n_errors, checked, bcn, cyc_n, i;
   int seed;
   gpib_ctl_model ctl (.core_clk(core_clk), .msg(msg), .msg_vld(msg_vld),
      .ifc(ifc), .my_listen(my_listen), .my_talk(my_talk),
      .poll_rd(poll_rd), .ren_pin(ren_pin));
   gpib_status_reporting DUT (.core_clk(core_clk), .rstn(rstn), .ev(ev),
      .lbus_err(p[4]), .lbus_tmo(p[5]), .mav(mav), .ese_wr(p[0]),
      .sre_wr(p[1]), .wr_data(wr_data), .ese_rd(p[7]), .esr_rd(p[6]),
      .stb_rd(p[8]), .cls_cmd(p[2]), .rst_cmd(p[3]), .msg(msg),
      .msg_vld(msg_vld), .ifc(ifc), .my_listen(my_listen),
      .my_talk(my_talk), .poll_rd(poll_rd), .ren_pin(ren_pin),
      .local_key(local_key), .reply_data(reply_data),
      .reply_vld(reply_vld), .poll_data(poll_data), .srq(srq),
      .talker(talker), .listener(listener), .poll_mode(poll_mode),
      .buf_clear(buf_clear), .rl_state(rl_state), .lockout(lockout),
      .keys_ok(keys_ok), .key_local_ok(key_local_ok));
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task finish_test();
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [7:0] s, input logic [7:0] x);
      checked++;
      if (s !== x) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, x, s);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // one pulse per call; the gap cycle keeps back-to-back calls clean
   task tp(input int k);
      cyc(1);
      p[k] = 1'b1;
      cyc(1);
      p[k] = 1'b0;
   endtask
   task wr(input int k, input logic [7:0] d);
      wr_data = d;
      tp(k);
   endtask
   // k: 0 event status, 1 enable mask, 2 status byte
   task q(input int k, input logic [7:0] x);
      exq.push_back(x);
      tp(6 + k);
   endtask
   task evp(input logic [3:0] e);
      cyc(1);
      ev = gpib_status_pkg::events_t'(e);
      cyc(1);
      ev = gpib_status_pkg::events_t'(4'h0);
   endtask
   task rl(input logic [7:0] x);
      chk("rl_state", 8'(rl_state), x);
   endtask
   always @(negedge core_clk) begin
      if (reply_vld === 1'b1) begin
         if (exq.size() > 0) begin
            chk("reply_data", reply_data, exq.pop_front());
         end else begin
            chk("reply_vld", 8'h01, 8'h00);
         end
      end
   end
   always @(posedge core_clk) begin
      cyc_n++;
      if (buf_clear === 1'b1) bcn++;
      if (cyc_n == 3000) begin
         n_errors++;
         finish_test();
      end
   end
   initial begin
      seed = 32'hA1F0;
      {rstn, mav, local_key, p, wr_data} = '0;
      ev = gpib_status_pkg::events_t'(4'h0);
      cyc(4);
      rstn = 1'b1;
      q(0, 8'h80);
      q(0, 8'h00);
      q(1, 8'h00);
      for (i = 0; i < 4; i++) begin
         v = 8'($random(seed));
         wr(0, v);
         q(1, v & `ESR_USED_MASK);
      end
      wr(0, 8'h10);
      evp(4'h8);
      q(2, 8'h00);
      evp(4'h4);
      q(2, 8'h20);
      q(0, 8'h30);
      q(2, 8'h00);
      wr(0, 8'h20);
      wr(1, 8'h20);
      evp(4'h8);
      cyc(3);
      chk("srq", 8'(srq), 8'h01);
      chk("poll_data", poll_data, 8'h60);
      q(2, 8'h60);
      q(2, 8'h60);
      ctl.poll();
      cyc(2);
      chk("srq", 8'(srq), 8'h00);
      chk("poll_data", poll_data, 8'h20);
      q(2, 8'h60);
      ctl.send(gpib_status_pkg::MSG_SPD);
      chk("poll_mode", 8'(poll_mode), 8'h00);
      ctl.send(gpib_status_pkg::MSG_UNT);
      chk("talker", 8'(talker), 8'h00);
      q(0, 8'h20);
      evp(4'h8);
      cyc(3);
      chk("srq", 8'(srq), 8'h01);
      mav = 1'b1;
      tp(4);
      tp(5);
      q(2, 8'h73);
      mav = 1'b0;
      q(2, 8'h63);
      mav = 1'b1;
      tp(2);
      q(2, 8'h10);
      chk("srq", 8'(srq), 8'h00);
      mav = 1'b0;
      q(2, 8'h00);
      evp(4'h3);
      q(0, 8'h09);
      // remote enable passes a synchroniser, so let it settle
      ctl.ren(1'b1);
      cyc(5);
      ctl.hit(1);
      cyc(1);
      rl(RM);
      chk("keys", {6'h00, keys_ok, key_local_ok}, 8'h01);
      ctl.hit(0);
      chk("listener", 8'(listener), 8'h00);
      rl(RM);
      ctl.hit(1);
      ctl.send(gpib_status_pkg::MSG_GTL);
      cyc(1);
      rl(LC);
      ctl.send(gpib_status_pkg::MSG_UNL);
      chk("listener", 8'(listener), 8'h00);
      ctl.send(gpib_status_pkg::MSG_LLO);
      ctl.hit(1);
      cyc(1);
      rl(LK);
      chk("keys", {6'h00, keys_ok, key_local_ok}, 8'h00);
      local_key = 1'b1;
      cyc(6);
      local_key = 1'b0;
      rl(LK);
      for (i = 0; i < 4; i++) begin
         ctl.send(ign[i]);
         rl(LK);
      end
      tp(3);
      cyc(1);
      rl(LK);
      chk("listener", 8'(listener), 8'h00);
      chk("buf_clear", 8'(bcn), 8'h01);
      q(1, 8'h00);
      evp(4'h8);
      ctl.send(gpib_status_pkg::MSG_DCL);
      cyc(1);
      rl(LC);
      chk("lockout", 8'(lockout), 8'h00);
      q(0, 8'h00);
      ctl.hit(1);
      evp(4'h4);
      ctl.send(gpib_status_pkg::MSG_SDC);
      cyc(1);
      chk("buf_clear", 8'(bcn), 8'h03);
      q(0, 8'h00);
      // panel local key returns a plain remote to local
      ctl.hit(1);
      local_key = 1'b1;
      cyc(6);
      local_key = 1'b0;
      rl(LC);
      // dropping remote enable cancels remote
      ctl.hit(1);
      cyc(1);
      rl(RM);
      ctl.ren(1'b0);
      cyc(6);
      rl(LC);
      wr(0, 8'hFF);
      rstn = 1'b0;
      cyc(2);
      rstn = 1'b1;
      q(0, 8'h80);
      q(1, 8'h00);
      rl(LC);
      finish_test();
   end
endmodule
`default_nettype wire
